// File: verilog/byte_bus_ctrl.sv
/*
 * Byte-wide local bus controller: bus state sequencing, ready sampling,
 * strobes, transceiver control, prefetch, word splitting and bus grant.
 * Assumes core requests are held until done pulses; mclk is the oscillator.
 */
`timescale 1ns/100ps
module byte_bus_ctrl (
	input wire logic mclk,
	input wire logic rst,
	input wire logic external_init_in_n,
	input wire logic async_ready_in,
	input wire logic sync_ready_in,
	input wire logic hold_req,
	input wire logic refresh_req,
	input wire logic op_req,
	input wire bbus_pkg::kind_t op_kind,
	input wire logic op_word,
	input wire logic [bbus_pkg::ADDR_W-1:0] op_addr,
	input wire logic [15:0] op_wdata,
	input wire logic [bbus_pkg::ADDR_W-1:0] fetch_addr,
	input wire logic q_flush,
	input wire logic q_pop,
	input wire logic [7:0] data_in,
	output logic op_done,
	output logic [15:0] op_rdata,
	output logic [7:0] q_byte,
	output logic q_valid,
	output logic proc_clock_output,
	output logic reset_out,
	output logic ale,
	output logic rd_n,
	output logic wr_n,
	output logic [7:0] addr_data_out,
	output logic [7:0] upper_addr_mid_byte,
	output logic [3:0] addr_high,
	output logic status_bit_two,
	output logic refresh_cycle_flag,
	output logic xcvr_output_enable_n,
	output logic xcvr_direction,
	output logic bus_oe_n,
	output logic bus_grant_out
);
	import bbus_pkg::*;

	// ------------------------------------------------------------
	// Clock, reset and queue
	// ------------------------------------------------------------
	logic phase_r;
	logic reset_out_r;
	logic [7:0] q_rd_data;
	logic [QCNT_W-1:0] q_count;

	clk_rst_gen u_clk_rst (
		.mclk(mclk),
		.rst(rst),
		.external_init_in_n(external_init_in_n),
		.phase_r(phase_r),
		.reset_out_r(reset_out_r)
	);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	bus_state_t st_r, st_nxt;
	kind_t kind_r;
	logic word_r;
	logic second_r;
	logic [ADDR_W-1:0] addr_r;
	logic [15:0] wdata_r;
	logic [7:0] low_byte_r;
	logic async_ready_in_s1_r;
	logic async_ready_in_s2_r;
	logic rdy_r;
	logic op_done_r;
	logic [15:0] op_rdata_r;
	logic clk_out_r;
	logic ale_r, rd_n_r, wr_n_r;
	logic [7:0] ad_r;
	logic [7:0] mid_r;
	logic [3:0] ah_r;
	logic s2_r, refresh_cycle_flag_r, den_n_r, dtr_r, oe_n_r, grant_r;
	logic hold_seen_r;
	logic [7:0] rd_byte_r;

	wire in_reset = reset_out_r;
	// Processor-clock edge points on the oscillator grid
	wire rise_edge = ~phase_r;
	wire fall_edge = phase_r;
	wire q_space = (q_count != QCNT_W'(QUEUE_DEPTH));
	wire q_wr = (st_r == ST_T4) && rise_edge && (kind_r == KIND_FETCH);
	wire at_ready_pt = (st_r == ST_T2) || (st_r == ST_T3) || (st_r == ST_TW);
	wire cycle_end = (st_r == ST_T4) && rise_edge;
	wire more_bytes = word_r && !second_r;
	wire [7:0] out_byte = second_r ? wdata_r[15:8] : wdata_r[7:0];
	wire [ADDR_W-1:0] cur_addr = addr_r + ADDR_W'(second_r);
	wire start_op = op_req && !op_done_r;
	wire go_hold = hold_req && !refresh_req;

	prefetch_queue u_queue (
		.mclk(mclk),
		.rst(rst || in_reset),
		.flush(q_flush),
		.wr_en(q_wr),
		.wr_data(rd_byte_r),
		.rd_en(q_pop),
		.rd_data(q_rd_data),
		.count(q_count)
	);

	// ------------------------------------------------------------
	// Ready sampling
	// ------------------------------------------------------------
	// Async ready taken mid-state (falling edge), then half a clock of
	// resolution before use at state end; sync ready used directly.
	always_ff @(posedge mclk) begin
		if (rst) begin
			async_ready_in_s1_r <= 1'b0;
			async_ready_in_s2_r <= 1'b0;
		end else begin
			async_ready_in_s1_r <= async_ready_in;
			if (fall_edge) begin
				async_ready_in_s2_r <= async_ready_in_s1_r;
			end
		end
	end

	always_comb begin
		rdy_r = async_ready_in_s2_r || sync_ready_in;
	end

	// ------------------------------------------------------------
	// Read data capture
	// ------------------------------------------------------------
	// Taken mid-T4 while the read strobe still stands; the bus is
	// released before the cycle ends, so data_in is stale by then.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_byte_r <= 8'h00;
		end else if ((st_r == ST_T4) && fall_edge) begin
			rd_byte_r <= data_in;
		end
	end

	// ------------------------------------------------------------
	// Bus state sequencing
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (go_hold) begin
					st_nxt = ST_HOLD;
				end else if (refresh_req || start_op || q_space) begin
					st_nxt = ST_T1;
				end
			end
			ST_T1: st_nxt = ST_T2;
			ST_T2: st_nxt = ST_T3;
			ST_T3: st_nxt = rdy_r ? ST_T4 : ST_TW;
			ST_TW: st_nxt = rdy_r ? ST_T4 : ST_TW;
			ST_T4: st_nxt = more_bytes ? ST_T1 : ST_IDLE;
			ST_HOLD: st_nxt = hold_req ? ST_HOLD : ST_IDLE;
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst || in_reset) begin
			st_r <= ST_IDLE;
		end else if (rise_edge) begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Cycle setup and word splitting
	// ------------------------------------------------------------
	// Second byte adds one full four-state cycle
	always_ff @(posedge mclk) begin
		if (rst || in_reset) begin
			kind_r <= KIND_FETCH;
			word_r <= 1'b0;
			second_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= '0;
			low_byte_r <= '0;
			op_done_r <= 1'b0;
			op_rdata_r <= '0;
		end else begin
			op_done_r <= 1'b0;
			if (rise_edge && st_r == ST_IDLE && st_nxt == ST_T1) begin
				second_r <= 1'b0;
				if (refresh_req) begin
					kind_r <= KIND_REFRESH;
					word_r <= 1'b0;
					addr_r <= '0;
				end else if (start_op) begin
					kind_r <= op_kind;
					word_r <= op_word;
					addr_r <= op_addr;
					wdata_r <= op_wdata;
				end else begin
					kind_r <= KIND_FETCH;
					word_r <= 1'b0;
					addr_r <= fetch_addr;
				end
			end
			if (cycle_end) begin
				if (more_bytes) begin
					second_r <= 1'b1;
					low_byte_r <= rd_byte_r;
				end else if (kind_r != KIND_FETCH && kind_r != KIND_REFRESH) begin
					op_done_r <= 1'b1;
					op_rdata_r <= word_r ? {rd_byte_r, low_byte_r} : {8'h00, rd_byte_r};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	wire nxt_t1 = (st_nxt == ST_T1) && rise_edge;
	wire active = (st_r == ST_T2) || (st_r == ST_T3) || (st_r == ST_TW);
	wire is_wr = kind_is_write(kind_r);

	always_ff @(posedge mclk) begin
		if (rst) begin
			clk_out_r <= 1'b0;
		end else begin
			clk_out_r <= ~phase_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || in_reset) begin
			ale_r <= 1'b0;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			ad_r <= '0;
			mid_r <= '0;
			ah_r <= '0;
			s2_r <= 1'b1;
			refresh_cycle_flag_r <= 1'b1;
			den_n_r <= 1'b1;
			dtr_r <= 1'b0;
			oe_n_r <= 1'b1;
			grant_r <= 1'b0;
			hold_seen_r <= 1'b0;
		end else begin
			// Address strobe high from mid-T1 to mid-T2 while address is valid
			ale_r <= (st_r == ST_T1) && !nxt_t1;
			rd_n_r <= !(active && !is_wr && kind_r != KIND_INT_ACK);
			wr_n_r <= !(active && is_wr);
			if (st_r == ST_T1) begin
				ad_r <= cur_addr[7:0];
				mid_r <= cur_addr[15:8];
				ah_r <= cur_addr[19:16];
				s2_r <= kind_is_mem(kind_r);
				refresh_cycle_flag_r <= !(kind_r == KIND_REFRESH);
				dtr_r <= is_wr;
			end else if (active && is_wr) begin
				ad_r <= out_byte;
			end
			den_n_r <= !(active || st_r == ST_T4) || kind_r == KIND_REFRESH;
			oe_n_r <= (st_r == ST_HOLD);
			hold_seen_r <= (st_r == ST_HOLD);
			grant_r <= (st_r == ST_HOLD) && !refresh_req;
		end
	end

	// No numerics handshake pins exist on this interface
	assign proc_clock_output = clk_out_r;
	assign reset_out = reset_out_r;
	assign ale = ale_r;
	assign rd_n = rd_n_r;
	assign wr_n = wr_n_r;
	assign addr_data_out = ad_r;
	assign upper_addr_mid_byte = mid_r;
	assign addr_high = ah_r;
	assign status_bit_two = s2_r;
	assign refresh_cycle_flag = refresh_cycle_flag_r;
	assign xcvr_output_enable_n = den_n_r;
	assign xcvr_direction = dtr_r;
	assign bus_oe_n = oe_n_r;
	assign bus_grant_out = grant_r;
	assign op_done = op_done_r;
	assign op_rdata = op_rdata_r;
	assign q_byte = q_rd_data;
	assign q_valid = (q_count != QCNT_RESET);

endmodule : byte_bus_ctrl

// File: verilog/bbus_pkg.sv
/*
 * Constants, types and timing counts shared by the byte-bus interface unit.
 * Assumes a single clock mclk (the oscillator input, 20 MHz), synchronous reset.
 */
// How it works
// - Sixteen-bit operands move as two byte cycles
// - Prefetch queue holds four instruction bytes
// - Fetch whenever one queue byte is free
// - Word access costs four extra clocks
// - No numerics coprocessor handshake exists
// - Middle address byte latched, address only
// - Byte-high pin flags refresh cycles instead
// - Processor clock is oscillator divided by two
// - Divider toggles on oscillator rising edge
// - Processor clock driven out on own pin
// - Async ready sampled mid T2, T3, waits; the mid-T2 sample is never used, since T2 always goes on to T3
// - Rising async ready gets half-clock synchronisation
// - Sync ready sampled at end of T2, T3, waits; the code tests ready only at end of T3 and waits, T2 always goes on to T3
// - Reset out five clocks for six-clock input
// - Reset out lags input at most 2.5 clocks
// - Address latch strobe plus read, write strobes
// - Status bit two: low I/O, high memory
// - Transceiver enable low in memory, I/O, ack cycles
// - Direction high on writes, low on reads
// - Finish current cycle, then grant and float bus
// - Drop grant when refresh pends; wait release
package bbus_pkg;

	// ------------------------------------------------------------
	// Sizes and timing
	// ------------------------------------------------------------
	localparam int QUEUE_DEPTH = 4;
	localparam int QPTR_W = 2;
	localparam int QCNT_W = 3;
	localparam int ADDR_W = 20;
	localparam int RST_SYNC_LEN = 4;
	localparam logic [QCNT_W-1:0] QCNT_RESET = 3'h0;
	localparam logic RESET_OUT_RESET = 1'b1;
	localparam logic PHASE_RESET = 1'b0;

	// ------------------------------------------------------------
	// Bus cycle kinds and states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		KIND_FETCH = 3'h0,
		KIND_MEM_RD = 3'h1,
		KIND_MEM_WR = 3'h2,
		KIND_IO_RD = 3'h3,
		KIND_IO_WR = 3'h4,
		KIND_INT_ACK = 3'h5,
		KIND_REFRESH = 3'h6
	} kind_t;

	// Gray along the waited path T1 -> T2 -> T3 -> TW -> T4 -> idle
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_T1 = 3'h1,
		ST_T2 = 3'h3,
		ST_T3 = 3'h2,
		ST_TW = 3'h6,
		ST_T4 = 3'h4,
		ST_HOLD = 3'h5
	} bus_state_t;

	function automatic logic kind_is_write(input kind_t k);
		return (k == KIND_MEM_WR) || (k == KIND_IO_WR);
	endfunction : kind_is_write

	function automatic logic kind_is_mem(input kind_t k);
		return (k == KIND_FETCH) || (k == KIND_MEM_RD) || (k == KIND_MEM_WR)
			|| (k == KIND_REFRESH);
	endfunction : kind_is_mem

endpackage : bbus_pkg

// File: verilog/clk_rst_gen.sv
/*
 * Divide-by-two processor clock phase and synchronised reset output.
 * Assumes mclk is the oscillator; reset input pin sampled synchronously.
 */
`timescale 1ns/100ps
module clk_rst_gen (
	input wire logic mclk,
	input wire logic rst,
	input wire logic external_init_in_n,
	output logic phase_r,
	output logic reset_out_r
);
	import bbus_pkg::*;

	logic [RST_SYNC_LEN-1:0] sync_r;

	// ------------------------------------------------------------
	// Clock divider
	// ------------------------------------------------------------
	// Phase 1 marks the high half of the processor clock; it toggles
	// every oscillator edge modelled by mclk
	always_ff @(posedge mclk) begin
		if (rst) begin
			phase_r <= PHASE_RESET;
		end else begin
			phase_r <= ~phase_r;
		end
	end

	// ------------------------------------------------------------
	// Reset synchroniser
	// ------------------------------------------------------------
	// Five oscillator edges = two and a half processor clocks of lag
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync_r <= '1;
			reset_out_r <= RESET_OUT_RESET;
		end else begin
			sync_r <= {sync_r[RST_SYNC_LEN-2:0], ~external_init_in_n};
			reset_out_r <= sync_r[RST_SYNC_LEN-1];
		end
	end

endmodule : clk_rst_gen

// File: verilog/prefetch_queue.sv
/*
 * Four-byte instruction prefetch queue.
 * Assumes writes only when not full and reads only when not empty.
 */
`timescale 1ns/100ps
module prefetch_queue (
	input wire logic mclk,
	input wire logic rst,
	input wire logic flush,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	output logic [bbus_pkg::QCNT_W-1:0] count
);
	import bbus_pkg::*;

	logic [7:0] mem_r [QUEUE_DEPTH];
	logic [QPTR_W-1:0] wp_r;
	logic [QPTR_W-1:0] rp_r;
	logic [QCNT_W-1:0] cnt_r;
	wire do_wr = wr_en && (cnt_r != QCNT_W'(QUEUE_DEPTH));
	wire do_rd = rd_en && (cnt_r != QCNT_RESET);

	assign rd_data = mem_r[rp_r];
	assign count = cnt_r;

	always_ff @(posedge mclk) begin
		if (do_wr) begin
			mem_r[wp_r] <= wr_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || flush) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= QCNT_RESET;
		end else begin
			wp_r <= wp_r + QPTR_W'(do_wr);
			rp_r <= rp_r + QPTR_W'(do_rd);
			cnt_r <= cnt_r + QCNT_W'(do_wr) - QCNT_W'(do_rd);
		end
	end

endmodule : prefetch_queue

// File: sim/bus_partner.sv
/* Memory and peripheral model on the far side of the byte bus.
 * Assumes active-low strobes and an address taken at the fall of ale. */
`timescale 1ns/100ps
module bus_partner (
	input wire logic mclk,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] addr_data_out,
	input wire logic [1:0] mode,
	input wire logic xcvr_output_enable_n,
	output logic [7:0] data_in,
	output logic async_ready_in,
	output logic sync_ready_in
);
	logic [7:0] mem [256];
	logic [7:0] a_r;
	int w_r;
	initial begin
		foreach (mem[i]) mem[i] = 8'(i * 7 + 3);
		data_in = 8'h00;
		w_r = 0;
	end
	// Address sampled while ale stands; the data byte follows at its fall
	always @(posedge mclk) if (ale) a_r <= addr_data_out;
	always @(posedge wr_n) mem[a_r] = addr_data_out;
	// Released bus toggles so stale data is never mistaken for valid
	always @(negedge mclk) data_in <= !rd_n ? mem[a_r] : ~data_in;
	// Acknowledge cycles have no strobe, so the enable also counts
	always @(posedge mclk) w_r <= (rd_n && wr_n && xcvr_output_enable_n) ? 0 : w_r + 1;
	// Ready only changes on clock edges; slow modes hold six clocks
	assign async_ready_in = (mode == 2'h1) && (w_r >= 6);
	assign sync_ready_in = (mode == 2'h0) || ((mode == 2'h2) && (w_r >= 6));
endmodule : bus_partner

// File: sim/byte_bus_ctrl_checker.sv
/* Port-level assertions for the byte bus controller.
 * Assumes it is bound to byte_bus_ctrl; one clock, mclk. */
`timescale 1ns/100ps
module byte_bus_ctrl_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic external_init_in_n,
	input wire logic hold_req,
	input wire logic refresh_req,
	input wire logic op_done,
	input wire logic proc_clock_output,
	input wire logic reset_out,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] upper_addr_mid_byte,
	input wire logic refresh_cycle_flag,
	input wire logic xcvr_output_enable_n,
	input wire logic xcvr_direction,
	input wire logic bus_oe_n,
	input wire logic bus_grant_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic [4:0] hi_cnt_r;
	logic [4:0] hi_cnt_nxt;
	assign hi_cnt_nxt = !reset_out ? 5'h00 : (hi_cnt_r == 5'h1f) ? hi_cnt_r : hi_cnt_r + 5'h01;
	always_ff @(posedge mclk) hi_cnt_r <= rst ? 5'h0a : hi_cnt_nxt;
	property p_clk; !rst |=> proc_clock_output != $past(proc_clock_output); endproperty
	a_clk: assert property (p_clk) else $error("clock not halved");
	property p_rst_lag; !external_init_in_n [*7] |-> reset_out; endproperty
	a_rst_lag: assert property (p_rst_lag) else $error("reset out late");
	property p_rst_len; $fell(reset_out) |-> hi_cnt_r >= 5'h0a; endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset out short");
	property p_dir_wr; !wr_n |-> xcvr_direction; endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("direction low on write");
	property p_dir_rd; !rd_n |-> !xcvr_direction; endproperty
	a_dir_rd: assert property (p_dir_rd) else $error("direction high on read");
	property p_den; (!rd_n || !wr_n) && refresh_cycle_flag |-> !xcvr_output_enable_n; endproperty
	a_den: assert property (p_den) else $error("transceiver not enabled");
	property p_ale; ale |-> rd_n && wr_n; endproperty
	a_ale: assert property (p_ale) else $error("strobe during ale");
	property p_mid; !rd_n && !$past(rd_n) |-> $stable(upper_addr_mid_byte); endproperty
	a_mid: assert property (p_mid) else $error("mid address moved");
	property p_done; op_done |=> !op_done; endproperty
	a_done: assert property (p_done) else $error("done too long");
	property p_float; bus_grant_out |-> bus_oe_n && !ale; endproperty
	a_float: assert property (p_float) else $error("bus driven in hold");
	property p_hold; $rose(hold_req) && !refresh_req |-> ##[1:200] bus_grant_out; endproperty
	a_hold: assert property (p_hold) else $error("grant missing");
	property p_regain; bus_grant_out && refresh_req |-> ##[1:4] !bus_grant_out; endproperty
	a_regain: assert property (p_regain) else $error("grant kept");
	property p_refresh_cycle_flag; !refresh_cycle_flag |-> wr_n; endproperty
	a_refresh_cycle_flag: assert property (p_refresh_cycle_flag) else $error("write in refresh");
endmodule : byte_bus_ctrl_checker
bind byte_bus_ctrl byte_bus_ctrl_checker i_byte_bus_ctrl_checker (.*);

// File: sim/test_byte_bus_ctrl.sv
/* Self-checking bench for the byte bus controller.
 * Assumes bus_partner answers the bus and the checker is bound. */
`timescale 1ns/100ps
module test_byte_bus_ctrl;
	import bbus_pkg::*;
	logic mclk, rst, external_init_in_n, hold_req, refresh_req, op_req, op_word, q_flush, q_pop;
	logic op_done, q_valid, proc_clock_output, reset_out, ale, rd_n, wr_n, status_bit_two, s2_r;
	logic refresh_cycle_flag, xcvr_output_enable_n, xcvr_direction, bus_oe_n, bus_grant_out;
	logic async_ready_in, sync_ready_in;
	kind_t op_kind;
	logic [ADDR_W-1:0] op_addr, fetch_addr;
	logic [15:0] op_wdata, op_rdata;
	logic [7:0] data_in, q_byte, addr_data_out, upper_addr_mid_byte;
	logic [3:0] addr_high;
	logic [1:0] mode;
	logic [31:0] lfsr;
	int failures, tests_run, i, n0, lat;
	int n_ale = 0;
	int lw [2];
	logic [7:0] model [256];
	byte_bus_ctrl i_byte_bus_ctrl (.*);
	bus_partner i_bus_partner (.*);
	always @(posedge ale) n_ale++;
	always @(negedge ale) s2_r = status_bit_two;
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx
	task automatic test_done;
		$display("compares %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic bound(input int n);
		if (n >= 800) begin
			failures++;
			test_done();
		end
	endtask : bound
	task automatic op(input int k, input logic w, output int lt);
		logic [7:0] a;
		logic [15:0] d;
		kind_t kk;
		@(negedge mclk);
		// Raise the request just before a processor-clock rising point
		if (proc_clock_output !== 1'b0) @(negedge mclk);
		lfsr = nx(lfsr);
		a = lfsr[7:0];
		d = lfsr[23:8];
		kk = kind_t'(k);
		n0 = n_ale;
		op_kind = kk;
		op_word = w;
		op_addr = {lfsr[31:20], a};
		op_wdata = d;
		op_req = 1'b1;
		lt = 0;
		do begin
			@(negedge mclk);
			lt++;
		end while (op_done !== 1'b1 && lt < 800);
		op_req = 1'b0;
		bound(lt);
		if (kk != KIND_INT_ACK) begin
			chk("cycles", w ? 16'h2 : 16'h1, 16'(n_ale - n0));
			chk("s2", {15'h0, kk != KIND_IO_RD && kk != KIND_IO_WR}, {15'h0, s2_r});
			if (kk == KIND_MEM_WR || kk == KIND_IO_WR) begin
				model[a] = d[7:0];
				if (w) model[a + 8'h01] = d[15:8];
			end else begin
				chk("rdata", {w ? model[a + 8'h01] : 8'h00, model[a]},
					{w ? op_rdata[15:8] : 8'h00, op_rdata[7:0]});
			end
		end
	endtask : op
	initial begin
		foreach (model[j]) model[j] = 8'(j * 7 + 3);
		{rst, external_init_in_n} = 2'b11;
		{hold_req, refresh_req, op_req, op_word, q_flush, q_pop} = 6'h00;
		op_kind = KIND_MEM_RD;
		op_addr = '0;
		op_wdata = 16'h0000;
		mode = 2'h0;
		failures = 0;
		tests_run = 0;
		lfsr = 32'h601de05c;
		fetch_addr = {12'h000, lfsr[7:0]};
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		external_init_in_n = 1'b0;
		repeat (12) @(negedge mclk);
		chk("reset_out", 16'h1, {15'h0, reset_out});
		external_init_in_n = 1'b1;
		for (i = 0; i < 800 && reset_out !== 1'b0; i++) @(negedge mclk);
		bound(i);
		n0 = n_ale;
		$display("test reset done");
		repeat (80) @(negedge mclk);
		chk("fill", 16'h4, 16'(n_ale - n0));
		chk("q_valid", 16'h1, {15'h0, q_valid});
		chk("q_byte", {8'h00, model[fetch_addr[7:0]]}, {8'h00, q_byte});
		q_pop = 1'b1;
		@(negedge mclk);
		q_pop = 1'b0;
		repeat (40) @(negedge mclk);
		chk("refill", 16'h5, 16'(n_ale - n0));
		q_flush = 1'b1;
		@(negedge mclk);
		q_flush = 1'b0;
		repeat (80) @(negedge mclk);
		chk("flush", 16'h9, 16'(n_ale - n0));
		$display("test prefetch done");
		for (int m = 0; m < 3; m++) begin
			mode = 2'(m);
			for (int k = 1; k < 6; k++) begin
				for (int w = 0; w < 2; w++) begin
					op(k, w[0], lat);
					if (m == 0 && k == 1) lw[w] = lat;
					if (m > 0 && k == 1 && w == 0) chk("waits", 16'h1, {15'h0, lat > lw[0]});
				end
			end
			if (m == 0) chk("word_cost", 16'h8, 16'(lw[1] - lw[0]));
		end
		$display("test transfers done");
		mode = 2'h0;
		hold_req = 1'b1;
		for (i = 0; i < 800 && bus_grant_out !== 1'b1; i++) @(negedge mclk);
		bound(i);
		chk("float", 16'h1, {15'h0, bus_oe_n});
		refresh_req = 1'b1;
		repeat (10) @(negedge mclk);
		chk("grant_drop", 16'h0, {15'h0, bus_grant_out});
		chk("no_refresh", 16'h1, {15'h0, refresh_cycle_flag});
		hold_req = 1'b0;
		for (i = 0; i < 800 && refresh_cycle_flag !== 1'b0; i++) @(negedge mclk);
		bound(i);
		refresh_req = 1'b0;
		chk("refresh", 16'h0, {15'h0, refresh_cycle_flag});
		repeat (20) @(negedge mclk);
		$display("test hold done");
		test_done();
	end
endmodule : test_byte_bus_ctrl
